// [hw/iod_access_if.sv]
// Carrier between the address decoder and the register space.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps

interface iod_access_if;
  import iod_pkg::*;
  logic valid;
  logic refused;
  iod_op_e op;
  logic [5:0] idx;
  logic [2:0] bit_sel;
  logic [7:0] wdata;
  modport dec (output valid, output refused, output op, output idx, output bit_sel, output wdata);
  modport space (input valid, input refused, input op, input idx, input bit_sel, input wdata);
endinterface

// [hw/iod_addr_decode.sv]
// Address decoder: unifies direct I/O and data-space requests into one access.
// Assumes at most one request per path per cycle, strobes synchronous to mclk.
`timescale 1ns/10ps

module iod_addr_decode
  import iod_pkg::*;
(
  input wire logic [5:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_wdata,
  input wire logic io_in,
  input wire logic io_out,
  input wire logic set_bit,
  input wire logic clr_bit,
  input wire logic skip_if_set,
  input wire logic skip_if_clr,
  input wire logic [7:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  input wire logic ds_load,
  input wire logic ds_store,
  iod_access_if.dec acc
);

  logic io_any;
  logic ds_any;
  logic ds_hit;
  logic [7:0] ds_rel;
  logic bit_kind;

  // Data-space requests are shifted down by the I/O window offset.
  assign ds_rel = ds_addr - `IOD_DS_OFFSET;
  assign ds_hit = (ds_addr >= `IOD_DS_OFFSET) && (ds_addr <= `IOD_DS_LAST);
  assign io_any = io_in | io_out | set_bit | clr_bit | skip_if_set | skip_if_clr;
  assign ds_any = ds_load | ds_store;
  assign bit_kind = set_bit | clr_bit | skip_if_set | skip_if_clr;

  // The direct path wins; a concurrent data-space request is refused.
  always_comb begin
    acc.valid = 1'b0;
    acc.refused = 1'b0;
    acc.op = IOD_OP_NONE;
    acc.idx = io_addr;
    acc.bit_sel = io_bit;
    acc.wdata = io_wdata;
    if (io_any) begin
      if (bit_kind && (io_addr > `IOD_BIT_LAST)) begin
        acc.refused = 1'b1;
      end else begin
        acc.valid = 1'b1;
        if (io_in) begin
          acc.op = IOD_OP_READ;
        end else if (io_out) begin
          acc.op = IOD_OP_WRITE;
        end else if (set_bit) begin
          acc.op = IOD_OP_SET;
        end else if (clr_bit) begin
          acc.op = IOD_OP_CLR;
        end else if (skip_if_set) begin
          acc.op = IOD_OP_TST_SET;
        end else begin
          acc.op = IOD_OP_TST_CLR;
        end
      end
      if (ds_any) begin
        acc.refused = 1'b1;
      end
    end else if (ds_any) begin
      acc.idx = ds_rel[5:0];
      acc.wdata = ds_wdata;
      if (ds_hit) begin
        acc.valid = 1'b1;
        acc.op = ds_load ? IOD_OP_READ : IOD_OP_WRITE;
      end else begin
        acc.refused = 1'b1;
      end
    end
  end

endmodule

// [hw/iod_bit_unit.sv]
// Next-value logic for one register: full writes, single-bit set and clear,
// write-one-to-clear flags and bit tests. Purely combinational.
// Assumes the caller supplies masks that are zero on reserved bits.
`timescale 1ns/10ps

module iod_bit_unit
  import iod_pkg::*;
(
  input wire iod_op_e op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] cur,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rw_mask,
  input wire logic [7:0] w1c_mask,
  input wire logic [7:0] ev_set,
  output logic [7:0] nxt,
  output logic test
);

  logic [7:0] one_hot;

  assign one_hot = 8'h01 << bit_sel;

  // Each operation touches only its own bits; hardware flag events win last.
  always_comb begin
    nxt = cur;
    test = 1'b0;
    case (op)
      IOD_OP_WRITE: begin
        nxt = (cur & ~rw_mask & ~w1c_mask) | (wdata & rw_mask) | (cur & w1c_mask & ~wdata);
      end
      IOD_OP_SET: begin
        if ((one_hot & w1c_mask) != 8'h00) begin
          nxt = cur & ~one_hot;
        end else begin
          nxt = cur | (one_hot & rw_mask);
        end
      end
      IOD_OP_CLR: begin
        nxt = cur & ~(one_hot & rw_mask);
      end
      IOD_OP_TST_SET: begin
        test = rd_val[bit_sel];
      end
      IOD_OP_TST_CLR: begin
        test = ~rd_val[bit_sel];
      end
      default: begin
        nxt = cur;
      end
    endcase
    nxt = nxt | (ev_set & w1c_mask);
  end

endmodule

// [hw/iod_io_space.sv]
// I/O register space of a small 8-bit controller: decoder, storage and
// access logic for the 64-byte space behind the processor core.
// Assumes the core presents one-cycle strobes synchronous to mclk and that
// peripherals take register contents from reg_image and side effects from
// the write and read event outputs.
`timescale 1ns/10ps

module iod_io_space
  import iod_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_wdata,
  input wire logic io_in,
  input wire logic io_out,
  input wire logic set_bit,
  input wire logic clr_bit,
  input wire logic skip_if_set,
  input wire logic skip_if_clr,
  input wire logic [7:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  input wire logic ds_load,
  input wire logic ds_store,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [5:0] rd_idx,
  output logic skip,
  output logic skip_valid,
  output logic refused,
  output logic wr_evt,
  output logic [5:0] wr_idx,
  output logic [7:0] wr_data,
  output logic [511:0] reg_image,
  input wire logic [2:0] pin_a,
  input wire logic [7:0] pin_b,
  input wire logic [6:0] pin_d,
  input wire logic cmp_out,
  input wire logic ser_rx_done,
  input wire logic ser_tx_empty,
  input wire logic ser_frame_err,
  input wire logic ser_overrun,
  input wire logic ser_parity_err,
  input wire logic shu_collision,
  input wire logic cmp_flag_evt,
  input wire logic ser_tx_done_evt,
  input wire logic shu_start_evt,
  input wire logic shu_ovf_evt,
  input wire logic shu_stop_evt,
  input wire logic wdg_flag_evt
);

  // --------------------------------------------------------------------------
  // Register field classification.
  // --------------------------------------------------------------------------

  // Bits that software stores; everything else at the address is either a
  // flag, a live status bit or reserved and therefore reads zero.
  function automatic logic [7:0] rw_mask(input logic [5:0] idx);
    case (idx)
      `IOD_OFS_CMP_DIS: rw_mask = `IOD_M_CMP_DIS;
      `IOD_OFS_SER_BAUD_HI: rw_mask = `IOD_M_BAUD_HI;
      `IOD_OFS_SER_FRAME: rw_mask = `IOD_M_FRAME;
      `IOD_OFS_CMP_CTRL: rw_mask = `IOD_M_CMP_RW;
      `IOD_OFS_SER_BAUD_LO: rw_mask = `IOD_M_FULL;
      `IOD_OFS_SER_CTRL: rw_mask = `IOD_M_FULL;
      `IOD_OFS_SER_STAT: rw_mask = `IOD_M_SER_RW;
      `IOD_OFS_SER_DATA: rw_mask = `IOD_M_FULL;
      `IOD_OFS_SHU_CTRL: rw_mask = `IOD_M_SHU_CTRL;
      `IOD_OFS_SHU_STAT: rw_mask = `IOD_M_SHU_RW;
      `IOD_OFS_SHU_DATA: rw_mask = `IOD_M_FULL;
      `IOD_OFS_PD_DIR: rw_mask = `IOD_M_PORT_D;
      `IOD_OFS_PD_OUT: rw_mask = `IOD_M_PORT_D;
      `IOD_OFS_SCR0: rw_mask = `IOD_M_FULL;
      `IOD_OFS_SCR1: rw_mask = `IOD_M_FULL;
      `IOD_OFS_SCR2: rw_mask = `IOD_M_FULL;
      `IOD_OFS_PB_DIR: rw_mask = `IOD_M_FULL;
      `IOD_OFS_PB_OUT: rw_mask = `IOD_M_FULL;
      `IOD_OFS_PA_DIR: rw_mask = `IOD_M_PORT_A;
      `IOD_OFS_PA_OUT: rw_mask = `IOD_M_PORT_A;
      `IOD_OFS_EE_CTRL: rw_mask = `IOD_M_EE_CTRL;
      `IOD_OFS_EE_DATA: rw_mask = `IOD_M_FULL;
      `IOD_OFS_EE_ADDR: rw_mask = `IOD_M_EE_ADDR;
      `IOD_OFS_PC_MASK: rw_mask = `IOD_M_FULL;
      `IOD_OFS_WDG_CTRL: rw_mask = `IOD_M_WDG_RW;
      `IOD_OFS_PRESC: rw_mask = `IOD_M_PRESC;
      `IOD_OFS_T1_CAP_LO: rw_mask = `IOD_M_FULL;
      default: rw_mask = `IOD_M_NONE;
    endcase
  endfunction

  // Flags that hardware sets and software clears by writing a one.
  function automatic logic [7:0] w1c_mask(input logic [5:0] idx);
    case (idx)
      `IOD_OFS_CMP_CTRL: w1c_mask = `IOD_M_CMP_W1C;
      `IOD_OFS_SER_STAT: w1c_mask = `IOD_M_SER_W1C;
      `IOD_OFS_SHU_STAT: w1c_mask = `IOD_M_SHU_W1C;
      `IOD_OFS_WDG_CTRL: w1c_mask = `IOD_M_WDG_W1C;
      default: w1c_mask = `IOD_M_NONE;
    endcase
  endfunction

  // Per-register set events of the flags above, aligned to their positions.
  function automatic logic [7:0] ev_byte(input logic [5:0] idx);
    case (idx)
      `IOD_OFS_CMP_CTRL: ev_byte = {3'b000, cmp_flag_evt, 4'b0000};
      `IOD_OFS_SER_STAT: ev_byte = {1'b0, ser_tx_done_evt, 6'b00_0000};
      `IOD_OFS_SHU_STAT: ev_byte = {shu_start_evt, shu_ovf_evt, shu_stop_evt, 5'b0_0000};
      `IOD_OFS_WDG_CTRL: ev_byte = {wdg_flag_evt, 7'b000_0000};
      default: ev_byte = 8'h00;
    endcase
  endfunction

  // Live bits that come straight from peripherals and pins, never stored.
  function automatic logic [7:0] live_byte(input logic [5:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IOD_OFS_CMP_CTRL: begin
        v[`IOD_POS_CMP_OUT] = cmp_out;
      end
      `IOD_OFS_SER_STAT: begin
        v[`IOD_POS_SER_RXDONE] = ser_rx_done;
        v[`IOD_POS_SER_EMPTY] = ser_tx_empty;
        v[`IOD_POS_SER_FERR] = ser_frame_err;
        v[`IOD_POS_SER_OVR] = ser_overrun;
        v[`IOD_POS_SER_PERR] = ser_parity_err;
      end
      `IOD_OFS_SHU_STAT: begin
        v[`IOD_POS_SHU_COLL] = shu_collision;
      end
      `IOD_OFS_PD_IN: begin
        v = {1'b0, pin_d};
      end
      `IOD_OFS_PB_IN: begin
        v = pin_b;
      end
      `IOD_OFS_PA_IN: begin
        v = {5'b0_0000, pin_a};
      end
      default: begin
        v = 8'h00;
      end
    endcase
    live_byte = v;
  endfunction

  // --------------------------------------------------------------------------
  // Access decoding and next-value computation.
  // --------------------------------------------------------------------------

  iod_access_if acc ();

  iod_state_s q;
  iod_state_s d;
  logic [7:0] cur_byte;
  logic [7:0] cur_rw;
  logic [7:0] cur_w1c;
  logic [7:0] cur_ev;
  logic [7:0] cur_rd;
  logic [7:0] bu_nxt;
  logic bu_test;

  // Both request paths collapse into one access toward the register space.
  iod_addr_decode u_dec (
    .io_addr(io_addr),
    .io_bit(io_bit),
    .io_wdata(io_wdata),
    .io_in(io_in),
    .io_out(io_out),
    .set_bit(set_bit),
    .clr_bit(clr_bit),
    .skip_if_set(skip_if_set),
    .skip_if_clr(skip_if_clr),
    .ds_addr(ds_addr),
    .ds_wdata(ds_wdata),
    .ds_load(ds_load),
    .ds_store(ds_store),
    .acc(acc)
  );

  // Values of the addressed register as seen by this access.
  assign cur_byte = q.regs[acc.idx];
  assign cur_rw = rw_mask(acc.idx);
  assign cur_w1c = w1c_mask(acc.idx);
  assign cur_ev = ev_byte(acc.idx);
  assign cur_rd = (cur_byte & (cur_rw | cur_w1c)) | live_byte(acc.idx);

  // One shared unit is enough since the core makes one access per cycle.
  iod_bit_unit u_bit (
    .op(acc.op),
    .bit_sel(acc.bit_sel),
    .wdata(acc.wdata),
    .cur(cur_byte),
    .rd_val(cur_rd),
    .rw_mask(cur_rw),
    .w1c_mask(cur_w1c),
    .ev_set(cur_ev),
    .nxt(bu_nxt),
    .test(bu_test)
  );

  // --------------------------------------------------------------------------
  // State update.
  // --------------------------------------------------------------------------

  // Flag events land on every register each cycle; the accessed register then
  // takes the unit's result, which already folds the same events in, so an
  // event in the cycle of its clear survives.
  always_comb begin
    d = q;
    d.rd_valid = 1'b0;
    d.skip_valid = 1'b0;
    d.wr_evt = 1'b0;
    d.refused = acc.refused;
    for (int i = 0; i < 64; i++) begin
      d.regs[i] = q.regs[i] | (ev_byte(6'(i)) & w1c_mask(6'(i)));
    end
    if (acc.valid) begin
      case (acc.op)
        IOD_OP_READ: begin
          d.rd_valid = 1'b1;
          d.rd_data = cur_rd;
          d.rd_idx = acc.idx;
        end
        IOD_OP_WRITE: begin
          d.regs[acc.idx] = bu_nxt;
          d.wr_evt = 1'b1;
          d.wr_idx = acc.idx;
          d.wr_data = acc.wdata & (cur_rw | cur_w1c | ~cur_rw); // Strobe bits pass to peripherals.
        end
        IOD_OP_SET, IOD_OP_CLR: begin
          d.regs[acc.idx] = bu_nxt;
          d.wr_evt = 1'b1;
          d.wr_idx = acc.idx;
          d.wr_data = bu_nxt;
        end
        IOD_OP_TST_SET, IOD_OP_TST_CLR: begin
          d.skip_valid = 1'b1;
          d.skip = bu_test;
        end
        default: begin
          d.skip_valid = 1'b0;
        end
      endcase
    end
  end

  // Synchronous reset clears every register, flag and answer.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all taken from flip-flops.
  // --------------------------------------------------------------------------

  // The image carries stored bits only; live bits come from the peripherals
  // themselves, so they are not echoed back here.
  assign reg_image = q.regs;
  assign rd_data = q.rd_data;
  assign rd_valid = q.rd_valid;
  assign rd_idx = q.rd_idx;
  assign skip = q.skip;
  assign skip_valid = q.skip_valid;
  assign refused = q.refused;
  assign wr_evt = q.wr_evt;
  assign wr_idx = q.wr_idx;
  assign wr_data = q.wr_data;

endmodule

// [hw/iod_params.svh]
// Constants of the I/O register space decoder: offsets, field masks, ranges.
// Assumes inclusion by bare name from the package and design files.
`ifndef IOD_PARAMS_SVH
`define IOD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Address ranges of the two access paths.
// ----------------------------------------------------------------------------
`define IOD_IO_LAST 6'h3F
`define IOD_BIT_LAST 6'h1F
`define IOD_DS_OFFSET 8'h20
`define IOD_DS_LAST 8'h5F

// ----------------------------------------------------------------------------
// Register offsets in the I/O space.
// ----------------------------------------------------------------------------
`define IOD_OFS_CMP_DIS 6'h01
`define IOD_OFS_SER_BAUD_HI 6'h02
`define IOD_OFS_SER_FRAME 6'h03
`define IOD_OFS_CMP_CTRL 6'h08
`define IOD_OFS_SER_BAUD_LO 6'h09
`define IOD_OFS_SER_CTRL 6'h0A
`define IOD_OFS_SER_STAT 6'h0B
`define IOD_OFS_SER_DATA 6'h0C
`define IOD_OFS_SHU_CTRL 6'h0D
`define IOD_OFS_SHU_STAT 6'h0E
`define IOD_OFS_SHU_DATA 6'h0F
`define IOD_OFS_PD_IN 6'h10
`define IOD_OFS_PD_DIR 6'h11
`define IOD_OFS_PD_OUT 6'h12
`define IOD_OFS_SCR0 6'h13
`define IOD_OFS_SCR1 6'h14
`define IOD_OFS_SCR2 6'h15
`define IOD_OFS_PB_IN 6'h16
`define IOD_OFS_PB_DIR 6'h17
`define IOD_OFS_PB_OUT 6'h18
`define IOD_OFS_PA_IN 6'h19
`define IOD_OFS_PA_DIR 6'h1A
`define IOD_OFS_PA_OUT 6'h1B
`define IOD_OFS_EE_CTRL 6'h1C
`define IOD_OFS_EE_DATA 6'h1D
`define IOD_OFS_EE_ADDR 6'h1E
`define IOD_OFS_PC_MASK 6'h20
`define IOD_OFS_WDG_CTRL 6'h21
`define IOD_OFS_T1_FORCE 6'h22
`define IOD_OFS_PRESC 6'h23
`define IOD_OFS_T1_CAP_LO 6'h24

// ----------------------------------------------------------------------------
// Field masks: stored writable bits, write-one-to-clear flags, live bits.
// ----------------------------------------------------------------------------
`define IOD_M_FULL 8'hFF
`define IOD_M_NONE 8'h00
`define IOD_M_CMP_DIS 8'h03
`define IOD_M_BAUD_HI 8'h0F
`define IOD_M_FRAME 8'h7F
`define IOD_M_CMP_RW 8'hCF
`define IOD_M_CMP_W1C 8'h10
`define IOD_POS_CMP_OUT 5
`define IOD_M_SER_RW 8'h03
`define IOD_M_SER_W1C 8'h40
`define IOD_POS_SER_RXDONE 7
`define IOD_POS_SER_EMPTY 5
`define IOD_POS_SER_FERR 4
`define IOD_POS_SER_OVR 3
`define IOD_POS_SER_PERR 2
`define IOD_M_SHU_CTRL 8'hFC
`define IOD_M_SHU_RW 8'h0F
`define IOD_M_SHU_W1C 8'hE0
`define IOD_POS_SHU_COLL 4
`define IOD_M_PORT_D 8'h7F
`define IOD_M_PORT_A 8'h07
`define IOD_M_EE_CTRL 8'h3F
`define IOD_M_EE_ADDR 8'h7F
`define IOD_M_WDG_RW 8'h7F
`define IOD_M_WDG_W1C 8'h80
`define IOD_M_PRESC 8'h01

`endif

// [hw/iod_pkg.sv]
// Types shared by the I/O register space decoder modules.
// Assumes iod_params.svh is on the include path.
`include "iod_params.svh"

package iod_pkg;

  // Kind of access presented to the register space.
  typedef enum logic [2:0] {
    IOD_OP_NONE,
    IOD_OP_READ,
    IOD_OP_WRITE,
    IOD_OP_SET,
    IOD_OP_CLR,
    IOD_OP_TST_SET,
    IOD_OP_TST_CLR
  } iod_op_e;

  // Complete state of the register space.
  typedef struct packed {
    logic [63:0][7:0] regs;
    logic [7:0] rd_data;
    logic [5:0] rd_idx;
    logic rd_valid;
    logic skip;
    logic skip_valid;
    logic refused;
    logic wr_evt;
    logic [5:0] wr_idx;
    logic [7:0] wr_data;
  } iod_state_s;

endpackage

// [verification/iod_core_model.sv]
// Behavioural processor core issuing one register request at a time.
// Assumes its tasks are called from one process and drive at falling edges.
`timescale 1ns/10ps

module iod_core_model (
  input wire logic mclk,
  output logic [5:0] io_addr,
  output logic [2:0] io_bit,
  output logic [7:0] io_wdata,
  output logic [5:0] io_stb,
  output logic [7:0] ds_addr,
  output logic [7:0] ds_wdata,
  output logic [1:0] ds_stb,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic skip,
  input wire logic skip_valid,
  input wire logic refused,
  input wire logic wr_evt
);
  // Idle bus at time zero, no strobe raised.
  initial {io_addr, io_bit, io_wdata, io_stb, ds_addr, ds_wdata, ds_stb} = 41'h0;

  // Strobe bit k: 0 in, 1 out, 2 set, 3 clear, 4 skip if set, 5 skip if clear.
  task automatic io_req(input int k, input logic [5:0] a, input logic [2:0] b, input logic [7:0] d,
                        output logic [7:0] q, output logic [3:0] f);
    @(negedge mclk);
    io_addr = a;
    io_bit = b;
    io_wdata = d;
    io_stb = 6'h01 << k;
    take(q, f);
  endtask

  // Strobe bit k: 0 load, 1 store.
  task automatic ds_req(input int k, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic [3:0] f);
    @(negedge mclk);
    ds_addr = a;
    ds_wdata = d;
    ds_stb = 2'h1 << k;
    take(q, f);
  endtask

  // Strobes stand one cycle; released lines show their inverse.
  task automatic take(output logic [7:0] q, output logic [3:0] f);
    @(negedge mclk);
    {io_stb, ds_stb} = 8'h00;
    {io_addr, io_bit, io_wdata, ds_addr, ds_wdata} = ~{io_addr, io_bit, io_wdata, ds_addr, ds_wdata};
    q = rd_valid ? rd_data : {7'h00, skip};
    f = {refused, wr_evt, skip_valid, rd_valid};
  endtask
endmodule

// [verification/iod_io_space_chk.sv]
// Concurrent checks on the ports of the I/O register space decoder.
// Assumes one mclk domain with a synchronous, active-high sys_rst.
`timescale 1ns/10ps

module iod_io_space_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [5:0] io_addr,
  input wire logic [2:0] io_bit,
  input wire logic [7:0] io_wdata,
  input wire logic io_in,
  input wire logic io_out,
  input wire logic set_bit,
  input wire logic clr_bit,
  input wire logic skip_if_set,
  input wire logic skip_if_clr,
  input wire logic [7:0] ds_addr,
  input wire logic ds_load,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [5:0] rd_idx,
  input wire logic skip,
  input wire logic skip_valid,
  input wire logic refused,
  input wire logic wr_evt,
  input wire logic [5:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [511:0] reg_image,
  input wire logic [7:0] pin_b,
  input wire logic shu_start_evt,
  input wire logic shu_ovf_evt,
  input wire logic shu_stop_evt,
  input wire logic wdg_flag_evt
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------------
  // Request classes in strobe priority.
  // --------------------------------------
  logic io_any, bit_req, tst_req, ds_only, pin_sel, wdg_flag, shu_sel, shu_ev;
  logic [7:0] shu_img, shu_clr;
  assign io_any = io_in | io_out | set_bit | clr_bit | skip_if_set | skip_if_clr;
  assign bit_req = (set_bit | clr_bit) & ~io_in & ~io_out;
  assign tst_req = (skip_if_set | skip_if_clr) & ~io_in & ~io_out & ~set_bit & ~clr_bit;
  assign ds_only = ds_load & ~io_any;
  assign pin_sel = pin_b[io_bit];
  assign wdg_flag = reg_image[271];
  // Aims at the three shift unit flags only.
  assign shu_sel = (io_addr == 6'h0E) && (io_bit >= 3'h5);
  assign shu_ev = shu_start_evt | shu_ovf_evt | shu_stop_evt;
  assign shu_img = reg_image[119:112];
  assign shu_clr = 8'h01 << io_bit;

  AST_IO_READ: assert property (io_in |=> rd_valid && rd_idx == $past(io_addr))
    else $error("Read index wrong");
  AST_DS_MAP: assert property (ds_only && ds_addr inside {[8'h20:8'h5F]} |=> rd_idx == 6'($past(ds_addr) - 8'h20))
    else $error("Load map wrong");
  AST_DS_RANGE: assert property (ds_only && !(ds_addr inside {[8'h20:8'h5F]}) |=> refused && !rd_valid)
    else $error("Load not refused");
  AST_BIT_HIGH: assert property (bit_req && io_addr > 6'h1F |=> refused && !wr_evt)
    else $error("High bit op taken");
  AST_BIT_LOW: assert property (bit_req && io_addr <= 6'h1F |=> wr_evt && !refused && wr_idx == $past(io_addr))
    else $error("Low bit op lost");
  AST_TEST_LOW: assert property (tst_req && io_addr <= 6'h1F |=> skip_valid && !refused)
    else $error("Low test lost");
  AST_TEST_PIN: assert property (tst_req && skip_if_set && io_addr == 6'h16 |=> skip == $past(pin_sel))
    else $error("Skip not pin");
  AST_FLAG_CLR: assert property (io_out && io_addr == 6'h21 && io_wdata[7] && !wdg_flag_evt |=> !wdg_flag)
    else $error("Flag not cleared");
  AST_FLAG_KEEP: assert property (io_out && io_addr == 6'h21 && !io_wdata[7] && !wdg_flag_evt |=> wdg_flag == $past(wdg_flag))
    else $error("Flag changed");
  AST_SET_ONE: assert property (set_bit && bit_req && shu_sel && !shu_ev |=> shu_img == ($past(shu_img) & ~$past(shu_clr)))
    else $error("Set hit other bits");
  AST_RSV_ZERO: assert property (io_in && io_addr inside {[6'h04:6'h07]} |=> rd_data == 8'h00)
    else $error("Reserved not zero");
  AST_WR_DATA: assert property (io_out && !io_in |=> wr_evt && wr_data == $past(io_wdata))
    else $error("Write data lost");
endmodule

bind iod_io_space iod_io_space_chk i_iod_io_space_chk (
  .mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr), .io_bit(io_bit), .io_wdata(io_wdata), .io_in(io_in),
  .io_out(io_out), .set_bit(set_bit), .clr_bit(clr_bit), .skip_if_set(skip_if_set), .skip_if_clr(skip_if_clr),
  .ds_addr(ds_addr), .ds_load(ds_load), .rd_data(rd_data), .rd_valid(rd_valid), .rd_idx(rd_idx), .skip(skip),
  .skip_valid(skip_valid), .refused(refused), .wr_evt(wr_evt), .wr_idx(wr_idx), .reg_image(reg_image),
  .pin_b(pin_b), .shu_start_evt(shu_start_evt), .shu_ovf_evt(shu_ovf_evt), .shu_stop_evt(shu_stop_evt),
  .wdg_flag_evt(wdg_flag_evt), .wr_data(wr_data)
);

// [verification/testbench.sv]
// Self-checking bench for the I/O register space decoder.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/10ps

module testbench;
  logic mclk, sys_rst, rd_valid, skip, skip_valid, refused, wr_evt;
  logic [5:0] io_addr, io_stb;
  logic [2:0] io_bit;
  logic [7:0] io_wdata, ds_addr, ds_wdata, rd_data, q;
  logic [1:0] ds_stb;
  logic [2:0] pin_a = 3'h0;
  logic [7:0] pin_b = 8'h00;
  logic [6:0] pin_d = 7'h00, st = 7'h00;
  logic [5:0] ev = 6'h00;
  logic [3:0] f;
  int err_total = 0, n_tests = 0, cyc = 0;
  // Address and stored mask of 23 of the 27 writable registers and of 0x22, which stores nothing.
  logic [15:0] rw_tab [24] = '{16'h0103, 16'h020F, 16'h037F, 16'h08CF, 16'h09FF, 16'h0AFF, 16'h0CFF, 16'h0FFF,
    16'h117F, 16'h127F, 16'h13FF, 16'h14FF, 16'h15FF, 16'h17FF, 16'h18FF, 16'h1A07, 16'h1B07, 16'h1DFF,
    16'h1E7F, 16'h20FF, 16'h217F, 16'h2200, 16'h2301, 16'h24FF};

  iod_io_space i_iod_io_space (
    .mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr), .io_bit(io_bit), .io_wdata(io_wdata),
    .io_in(io_stb[0]), .io_out(io_stb[1]), .set_bit(io_stb[2]), .clr_bit(io_stb[3]),
    .skip_if_set(io_stb[4]), .skip_if_clr(io_stb[5]), .ds_addr(ds_addr), .ds_wdata(ds_wdata),
    .ds_load(ds_stb[0]), .ds_store(ds_stb[1]), .rd_data(rd_data), .rd_valid(rd_valid), .rd_idx(),
    .skip(skip), .skip_valid(skip_valid), .refused(refused), .wr_evt(wr_evt), .wr_idx(), .wr_data(),
    .reg_image(), .pin_a(pin_a), .pin_b(pin_b), .pin_d(pin_d), .cmp_out(st[0]), .ser_rx_done(st[1]),
    .ser_tx_empty(st[2]), .ser_frame_err(st[3]), .ser_overrun(st[4]), .ser_parity_err(st[5]),
    .shu_collision(st[6]), .cmp_flag_evt(ev[0]), .ser_tx_done_evt(ev[1]), .shu_start_evt(ev[2]),
    .shu_ovf_evt(ev[3]), .shu_stop_evt(ev[4]), .wdg_flag_evt(ev[5])
  );

  iod_core_model i_iod_core_model (
    .mclk(mclk), .io_addr(io_addr), .io_bit(io_bit), .io_wdata(io_wdata), .io_stb(io_stb),
    .ds_addr(ds_addr), .ds_wdata(ds_wdata), .ds_stb(ds_stb), .rd_data(rd_data), .rd_valid(rd_valid),
    .skip(skip), .skip_valid(skip_valid), .refused(refused), .wr_evt(wr_evt)
  );

  // 40 MHz core clock.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // --------------------------------------
  // Access and comparison tasks.
  // --------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic io(input int k, input logic [5:0] a, input logic [2:0] b, input logic [7:0] d);
    i_iod_core_model.io_req(k, a, b, d, q, f);
  endtask

  task automatic ds(input int k, input logic [7:0] a, input logic [7:0] d);
    i_iod_core_model.ds_req(k, a, d, q, f);
  endtask

  task automatic rio(input logic [5:0] a, input logic [7:0] exp);
    io(0, a, 3'h0, 8'h00);
    chk("io read", exp, q);
  endtask

  // Flags seen: refused, write event, skip valid, read valid.
  task automatic cf(input logic [3:0] exp);
    chk("answer flags", {4'h0, exp}, {4'h0, f});
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ceiling far above the few hundred cycles the tests need.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      give_verdict();
    end
  end

  // --------------------------------------
  // Test sequence.
  // --------------------------------------
  initial begin
    sys_rst = 1'b1;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    for (int a = 0; a < 64; a++) rio(6'(a), 8'h00);
    $display("reset values done");
    // Reserved bits written as ones must drop.
    foreach (rw_tab[i]) begin
      io(1, rw_tab[i][13:8], 3'h0, 8'hFF);
      ds(0, {2'h0, rw_tab[i][13:8]} + 8'h20, 8'h00);
      chk("ds read", rw_tab[i][7:0], q);
      ds(1, {2'h0, rw_tab[i][13:8]} + 8'h20, 8'h5A);
      rio(rw_tab[i][13:8], rw_tab[i][7:0] & 8'h5A);
    end
    $display("two paths done");
    ds(0, 8'h1F, 8'h00);
    cf(4'b1000);
    ds(0, 8'h60, 8'h00);
    cf(4'b1000);
    ds(1, 8'h60, 8'h33);
    cf(4'b1000);
    ds(0, 8'h5F, 8'h00);
    cf(4'b0001);
    $display("data window done");
    io(2, 6'h1F, 3'h0, 8'h00);
    cf(4'b0100);
    io(2, 6'h20, 3'h0, 8'h00);
    cf(4'b1000);
    rio(6'h20, 8'h5A);
    io(2, 6'h1B, 3'h2, 8'h00);
    rio(6'h1B, 8'h06);
    io(3, 6'h1B, 3'h1, 8'h00);
    rio(6'h1B, 8'h04);
    $display("bit range done");
    @(negedge mclk);
    ev = 6'h3F;
    @(negedge mclk);
    ev = 6'h00;
    rio(6'h0E, 8'hE0);
    rio(6'h0B, 8'h40);
    rio(6'h21, 8'hDA);
    io(2, 6'h0B, 3'h6, 8'h00);
    rio(6'h0B, 8'h00);
    io(2, 6'h0E, 3'h6, 8'h00);
    rio(6'h0E, 8'hA0);
    io(3, 6'h0E, 3'h7, 8'h00);
    rio(6'h0E, 8'hA0);
    io(1, 6'h0E, 3'h0, 8'h20);
    rio(6'h0E, 8'h80);
    io(2, 6'h0E, 3'h0, 8'h00);
    rio(6'h0E, 8'h81);
    io(1, 6'h21, 3'h0, 8'h80);
    rio(6'h21, 8'h00);
    $display("flags done");
    pin_b = 8'h24;
    for (int b = 0; b < 8; b++) begin
      io(4, 6'h16, 3'(b), 8'h00);
      chk("skip if set", {7'h00, pin_b[b]}, q);
      io(5, 6'h16, 3'(b), 8'h00);
      chk("skip if clear", {7'h00, ~pin_b[b]}, q);
    end
    io(5, 6'h1F, 3'h3, 8'h00);
    chk("skip boundary", 8'h01, q);
    io(4, 6'h20, 3'h0, 8'h00);
    cf(4'b1000);
    $display("bit tests done");
    st = 7'h7F;
    pin_a = 3'h5;
    pin_d = 7'h55;
    rio(6'h0B, 8'hBC);
    rio(6'h19, 8'h05);
    rio(6'h10, 8'h55);
    rio(6'h0E, 8'h91);
    $display("live status done");
    give_verdict();
  end
endmodule
